//--- hw/sbt_cfg.svh
// Constants for the sixteen-bit counter/timer: offsets, field positions and reset values.
`ifndef SBT_CFG_SVH
`define SBT_CFG_SVH
`define SBT_W 16
`define SBT_AW 8
`define SBT_DW 32
`define SBT_NCH 4
`define SBT_NIRQ 5
`define SBT_ZERO16 16'h0000
`define SBT_ONE16 16'h0001
`define SBT_OFS_IR 8'h00
`define SBT_OFS_TCR 8'h04
`define SBT_OFS_TC 8'h08
`define SBT_OFS_PR 8'h0C
`define SBT_OFS_PC 8'h10
`define SBT_OFS_MCR 8'h14
`define SBT_OFS_MR0 8'h18
`define SBT_OFS_MR1 8'h1C
`define SBT_OFS_MR2 8'h20
`define SBT_OFS_MR3 8'h24
`define SBT_OFS_CCR 8'h28
`define SBT_OFS_CAP 8'h2C
`define SBT_OFS_EMR 8'h3C
`define SBT_OFS_COUNT_SOURCE_CONTROL 8'h70
`define SBT_OFS_PWMC 8'h74
`define SBT_TCR_EN 0
`define SBT_TCR_RST 1
`define SBT_MCR_INT 0
`define SBT_MCR_RST 1
`define SBT_MCR_STOP 2
`define SBT_MCR_STRIDE 3
`define SBT_MCR_W 12
`define SBT_CCR_RISE 0
`define SBT_CCR_FALL 1
`define SBT_CCR_INT 2
`define SBT_CCR_W 3
`define SBT_IR_CAP 4
`define SBT_EMR_CTRL 4
`define SBT_EMC_W 8
`define SBT_COUNT_SOURCE_CONTROL_MODE 0
`define SBT_COUNT_SOURCE_CONTROL_SEL 2
`define SBT_INSEL_CAP 2'h0
`define SBT_EMC_NONE 2'h0
`define SBT_EMC_LOW 2'h1
`define SBT_EMC_HIGH 2'h2
`define SBT_EMC_TGL 2'h3
`endif

//--- hw/sbt_pkg.sv
// Types shared by the sixteen-bit counter/timer modules.
`include "sbt_cfg.svh"
package sbt_pkg;
    typedef enum logic [1:0] {SBT_MODE_TIMER, SBT_MODE_RISE, SBT_MODE_FALL, SBT_MODE_BOTH} sbt_mode_e;
    typedef logic [`SBT_W-1:0] sbt_word_t;
    typedef struct packed {
        logic [`SBT_NIRQ-1:0] ir;
        logic en;
        logic rst;
        sbt_word_t tc;
        sbt_word_t pr;
        sbt_word_t pc;
        logic [`SBT_MCR_W-1:0] match_control;
        sbt_word_t [`SBT_NCH-1:0] mr;
        logic [`SBT_CCR_W-1:0] capture_control;
        sbt_word_t cap;
        logic [`SBT_EMC_W-1:0] emc;
        sbt_mode_e mode;
        logic [1:0] insel;
        logic [`SBT_NCH-1:0] pwm;
        logic [`SBT_NCH-1:0] hit_q;
        logic [`SBT_DW-1:0] rdata;
    } sbt_state_s;
    typedef struct packed {
        logic prev;
    } sbt_edge_s;
    typedef struct packed {
        logic pin;
    } sbt_pin_s;
endpackage : sbt_pkg

//--- hw/sbt_edge.sv
// Edge detector for the capture input, with separate rising and falling enables.
`timescale 1ns/10ps
`include "sbt_cfg.svh"
module sbt_edge
    import sbt_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    input wire logic i_sig,
    input wire logic i_rise_en,
    input wire logic i_fall_en,
    output logic o_evt
);
    sbt_edge_s s_reg;
    sbt_edge_s s_next;

    // The previous level is remembered for edge comparison.
    always_comb
    begin
        s_next = s_reg;
        s_next.prev = i_sig;
    end

    // State holds while the clock enable is low.
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rstn)
            s_reg <= '0;
        else if (i_ce)
            s_reg <= s_next;
    end

    // A selected edge gives a one-cycle strobe.
    assign o_evt = i_ce & ((i_rise_en & i_sig & ~s_reg.prev) | (i_fall_en & ~i_sig & s_reg.prev));
endmodule : sbt_edge

//--- hw/sbt_match_pin.sv
// One external match output: set, clear, toggle on match, or single-edge PWM.
`timescale 1ns/10ps
`include "sbt_cfg.svh"
module sbt_match_pin
    import sbt_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    input wire logic i_hit,
    input wire logic [1:0] i_ctrl,
    input wire logic i_pwm,
    input wire logic i_ge,
    input wire logic i_wr,
    input wire logic i_wbit,
    output logic o_pin
);
    sbt_pin_s s_reg;
    sbt_pin_s s_next;

    // Software write wins, then PWM level, then the match action.
    always_comb
    begin
        s_next = s_reg;
        if (i_wr)
            s_next.pin = i_wbit;
        else if (i_pwm)
            s_next.pin = i_ge;
        else if (i_hit)
        begin
            case (i_ctrl)
                `SBT_EMC_LOW: s_next.pin = 1'b0;
                `SBT_EMC_HIGH: s_next.pin = 1'b1;
                `SBT_EMC_TGL: s_next.pin = ~s_reg.pin;
                default: s_next.pin = s_reg.pin;
            endcase
        end
    end

    // Pin state register.
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rstn)
            s_reg <= '0;
        else if (i_ce)
            s_reg <= s_next;
    end

    assign o_pin = s_reg.pin;

    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rstn);

    property p_toggle;
        i_ce && i_hit && !i_pwm && !i_wr && i_ctrl == `SBT_EMC_TGL |=> o_pin != $past(o_pin);
    endproperty
    a_toggle: assert property (p_toggle) else $error("match toggle did not toggle");

    property p_pwm_level;
        i_ce && i_pwm && !i_wr |=> o_pin == $past(i_ge);
    endproperty
    a_pwm_level: assert property (p_pwm_level) else $error("pwm level wrong");
endmodule : sbt_match_pin

//--- hw/sbt_timer.sv
// Sixteen-bit counter/timer with prescaler, four matches, one capture and match outputs.
//
// Added by the designer: the plain strobed port.
`timescale 1ns/10ps
`include "sbt_cfg.svh"
module sbt_timer
    import sbt_pkg::*;
#(
    parameter int NUM_PINS = 3
)
(
    input wire logic i_core_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    input wire logic [`SBT_AW-1:0] i_addr,
    input wire logic [`SBT_DW-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [`SBT_DW-1:0] o_rdata,
    input wire logic i_cap,
    output logic [NUM_PINS-1:0] o_match
);
    sbt_state_s s_reg;
    sbt_state_s s_next;
    logic [`SBT_NCH-1:0] eq;
    logic [`SBT_NCH-1:0] hit;
    logic [`SBT_NCH-1:0] pins;
    logic [`SBT_NIRQ-1:0] set_flags;
    logic [`SBT_NIRQ-1:0] clr_flags;
    logic rst_hit;
    logic stop_now;
    logic tick;
    logic cnt_evt;
    logic cap_evt;
    logic wr_tc;
    logic wr_pc;
    logic wr_tcr;
    logic wr_emr;

    // Picks one control bit of one channel out of the match control field.
    function automatic logic mcr_bit(input logic [`SBT_MCR_W-1:0] match_control, input int ch, input int kind);
        mcr_bit = match_control[ch * `SBT_MCR_STRIDE + kind];
    endfunction : mcr_bit

    // Write strobes that the match pin units, the flag logic and the checks need.
    assign wr_tc = i_wr & (i_addr == `SBT_OFS_TC);
    assign wr_pc = i_wr & (i_addr == `SBT_OFS_PC);
    assign wr_tcr = i_wr & (i_addr == `SBT_OFS_TCR);
    assign wr_emr = i_wr & (i_addr == `SBT_OFS_EMR);
    assign clr_flags = (i_wr & (i_addr == `SBT_OFS_IR)) ? i_wdata[`SBT_NIRQ-1:0] : '0;

    // Edge source for counter mode, chosen by the count control mode.
    sbt_edge u_cnt_edge (
        .i_core_clk(i_core_clk),
        .i_rstn(i_rstn),
        .i_ce(i_ce),
        .i_sig(i_cap),
        .i_rise_en(s_reg.mode == SBT_MODE_RISE || s_reg.mode == SBT_MODE_BOTH),
        .i_fall_en(s_reg.mode == SBT_MODE_FALL || s_reg.mode == SBT_MODE_BOTH),
        .o_evt(cnt_evt)
    );

    // Edge source for capture, chosen by the capture control bits.
    sbt_edge u_cap_edge (
        .i_core_clk(i_core_clk),
        .i_rstn(i_rstn),
        .i_ce(i_ce),
        .i_sig(i_cap),
        .i_rise_en(s_reg.capture_control[`SBT_CCR_RISE]),
        .i_fall_en(s_reg.capture_control[`SBT_CCR_FALL]),
        .o_evt(cap_evt)
    );

    // Match compare per channel; an event fires on the first cycle of equality.
    always_comb
    begin
        eq = '0;
        hit = '0;
        rst_hit = 1'b0;
        stop_now = 1'b0;
        set_flags = '0;
        for (int i = 0; i < `SBT_NCH; i++)
        begin
            eq[i] = (s_reg.tc == s_reg.mr[i]);
            hit[i] = eq[i] & ~s_reg.hit_q[i];
            rst_hit = rst_hit | (eq[i] & mcr_bit(s_reg.match_control, i, `SBT_MCR_RST));
            stop_now = stop_now | (hit[i] & mcr_bit(s_reg.match_control, i, `SBT_MCR_STOP));
            set_flags[i] = hit[i] & mcr_bit(s_reg.match_control, i, `SBT_MCR_INT);
        end
        set_flags[`SBT_IR_CAP] = cap_evt & s_reg.capture_control[`SBT_CCR_INT];
    end

    // One prescaler step: every clock in timer mode, every selected edge in counter mode when the input select picks the capture pin.
    assign tick = s_reg.en & ~s_reg.rst & ~stop_now &
        ((s_reg.mode == SBT_MODE_TIMER) | (cnt_evt & (s_reg.insel == `SBT_INSEL_CAP)));

    // Next-state logic: counting first, then hardware events, then software writes.
    always_comb
    begin
        s_next = s_reg;
        s_next.rdata = '0;
        s_next.hit_q = eq;
        if (s_reg.rst)
        begin
            s_next.tc = `SBT_ZERO16;
            s_next.pc = `SBT_ZERO16;
        end
        else if (tick)
        begin
            if (s_reg.pc == s_reg.pr)
            begin
                s_next.pc = `SBT_ZERO16;
                s_next.tc = rst_hit ? `SBT_ZERO16 : s_reg.tc + `SBT_ONE16;
            end
            else
                s_next.pc = s_reg.pc + `SBT_ONE16;
        end
        if (stop_now)
            s_next.en = 1'b0;
        // A flag raised in the cycle it is cleared stays set.
        s_next.ir = (s_reg.ir & ~clr_flags) | set_flags;
        if (cap_evt)
            s_next.cap = s_reg.tc;
        if (i_wr)
        begin
            case (i_addr)
                `SBT_OFS_TCR:
                begin
                    s_next.en = i_wdata[`SBT_TCR_EN];
                    s_next.rst = i_wdata[`SBT_TCR_RST];
                end
                `SBT_OFS_TC: s_next.tc = i_wdata[`SBT_W-1:0];
                `SBT_OFS_PR: s_next.pr = i_wdata[`SBT_W-1:0];
                `SBT_OFS_PC: s_next.pc = i_wdata[`SBT_W-1:0];
                `SBT_OFS_MCR: s_next.match_control = i_wdata[`SBT_MCR_W-1:0];
                `SBT_OFS_MR0: s_next.mr[0] = i_wdata[`SBT_W-1:0];
                `SBT_OFS_MR1: s_next.mr[1] = i_wdata[`SBT_W-1:0];
                `SBT_OFS_MR2: s_next.mr[2] = i_wdata[`SBT_W-1:0];
                `SBT_OFS_MR3: s_next.mr[3] = i_wdata[`SBT_W-1:0];
                `SBT_OFS_CCR: s_next.capture_control = i_wdata[`SBT_CCR_W-1:0];
                `SBT_OFS_EMR: s_next.emc = i_wdata[`SBT_EMR_CTRL +: `SBT_EMC_W];
                `SBT_OFS_COUNT_SOURCE_CONTROL:
                begin
                    s_next.mode = sbt_mode_e'(i_wdata[`SBT_COUNT_SOURCE_CONTROL_MODE +: 2]);
                    s_next.insel = i_wdata[`SBT_COUNT_SOURCE_CONTROL_SEL +: 2];
                end
                `SBT_OFS_PWMC: s_next.pwm = i_wdata[`SBT_NCH-1:0];
                default: s_next.en = s_next.en;
            endcase
        end
        if (i_rd)
        begin
            case (i_addr)
                `SBT_OFS_IR: s_next.rdata[`SBT_NIRQ-1:0] = s_reg.ir;
                `SBT_OFS_TCR:
                begin
                    s_next.rdata[`SBT_TCR_EN] = s_reg.en;
                    s_next.rdata[`SBT_TCR_RST] = s_reg.rst;
                end
                `SBT_OFS_TC: s_next.rdata[`SBT_W-1:0] = s_reg.tc;
                `SBT_OFS_PR: s_next.rdata[`SBT_W-1:0] = s_reg.pr;
                `SBT_OFS_PC: s_next.rdata[`SBT_W-1:0] = s_reg.pc;
                `SBT_OFS_MCR: s_next.rdata[`SBT_MCR_W-1:0] = s_reg.match_control;
                `SBT_OFS_MR0: s_next.rdata[`SBT_W-1:0] = s_reg.mr[0];
                `SBT_OFS_MR1: s_next.rdata[`SBT_W-1:0] = s_reg.mr[1];
                `SBT_OFS_MR2: s_next.rdata[`SBT_W-1:0] = s_reg.mr[2];
                `SBT_OFS_MR3: s_next.rdata[`SBT_W-1:0] = s_reg.mr[3];
                `SBT_OFS_CCR: s_next.rdata[`SBT_CCR_W-1:0] = s_reg.capture_control;
                `SBT_OFS_CAP: s_next.rdata[`SBT_W-1:0] = s_reg.cap;
                `SBT_OFS_EMR:
                begin
                    s_next.rdata[`SBT_NCH-1:0] = pins;
                    s_next.rdata[`SBT_EMR_CTRL +: `SBT_EMC_W] = s_reg.emc;
                end
                `SBT_OFS_COUNT_SOURCE_CONTROL:
                begin
                    s_next.rdata[`SBT_COUNT_SOURCE_CONTROL_MODE +: 2] = s_reg.mode;
                    s_next.rdata[`SBT_COUNT_SOURCE_CONTROL_SEL +: 2] = s_reg.insel;
                end
                `SBT_OFS_PWMC: s_next.rdata[`SBT_NCH-1:0] = s_reg.pwm;
                default: s_next.rdata = '0;
            endcase
        end
    end

    // All state clears on reset and freezes while the clock enable is low.
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rstn)
            s_reg <= '0;
        else if (i_ce)
            s_reg <= s_next;
    end

    // One match output unit per channel; the unpinned ones still keep state.
    for (genvar g = 0; g < `SBT_NCH; g++)
    begin : g_pin
        sbt_match_pin u_pin (
            .i_core_clk(i_core_clk),
            .i_rstn(i_rstn),
            .i_ce(i_ce),
            .i_hit(hit[g]),
            .i_ctrl(s_reg.emc[2 * g +: 2]),
            .i_pwm(s_reg.pwm[g]),
            .i_ge(s_reg.tc >= s_reg.mr[g]),
            .i_wr(wr_emr),
            .i_wbit(i_wdata[g]),
            .o_pin(pins[g])
        );
    end

    assign o_match = pins[NUM_PINS-1:0];
    assign o_rdata = s_reg.rdata;

    // Checks run on the core clock; all but the reset check rest while reset is held.
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rstn);

    property p_wrap;
        i_ce && tick && s_reg.pc == s_reg.pr && !rst_hit && !wr_tc && !wr_pc
            |=> s_reg.tc == $past(s_reg.tc) + `SBT_ONE16 && s_reg.pc == `SBT_ZERO16;
    endproperty
    a_wrap: assert property (p_wrap) else $error("count did not step at prescale limit");

    property p_prescale;
        i_ce && tick && s_reg.pc != s_reg.pr && !wr_tc && !wr_pc
            |=> s_reg.pc == $past(s_reg.pc) + `SBT_ONE16 && $stable(s_reg.tc);
    endproperty
    a_prescale: assert property (p_prescale) else $error("prescaler step wrong");

    property p_tcr_reset;
        i_ce && s_reg.rst && !wr_tc && !wr_pc |=> s_reg.tc == `SBT_ZERO16 && s_reg.pc == `SBT_ZERO16;
    endproperty
    a_tcr_reset: assert property (p_tcr_reset) else $error("count reset not applied");

    property p_disabled;
        i_ce && !s_reg.en && !s_reg.rst && !wr_tc && !wr_pc |=> $stable(s_reg.tc) && $stable(s_reg.pc);
    endproperty
    a_disabled: assert property (p_disabled) else $error("count moved while disabled");

    property p_match_reset;
        i_ce && tick && rst_hit && s_reg.pc == s_reg.pr && !wr_tc |=> s_reg.tc == `SBT_ZERO16;
    endproperty
    a_match_reset: assert property (p_match_reset) else $error("reset on match failed");

    property p_stop;
        i_ce && stop_now && !wr_tcr |=> !s_reg.en ##1 (!i_ce || $stable(s_reg.tc) || wr_tc || s_reg.en);
    endproperty
    a_stop: assert property (p_stop) else $error("stop on match did not halt");

    property p_flag_keep;
        i_ce |=> (s_reg.ir & $past(s_reg.ir) & ~$past(clr_flags)) == ($past(s_reg.ir) & ~$past(clr_flags));
    endproperty
    a_flag_keep: assert property (p_flag_keep) else $error("flag lost without clear");

    property p_flag_clear;
        i_ce && clr_flags == '1 && set_flags == '0 |=> s_reg.ir == '0;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flags not cleared");

    property p_match_flag;
        i_ce && hit[0] && mcr_bit(s_reg.match_control, 0, `SBT_MCR_INT) |=> s_reg.ir[0];
    endproperty
    a_match_flag: assert property (p_match_flag) else $error("match flag not raised");

    property p_capture;
        i_ce && cap_evt |=> s_reg.cap == $past(s_reg.tc);
    endproperty
    a_capture: assert property (p_capture) else $error("capture value wrong");

    property p_cap_flag;
        i_ce && cap_evt && s_reg.capture_control[`SBT_CCR_INT] |=> s_reg.ir[`SBT_IR_CAP];
    endproperty
    a_cap_flag: assert property (p_cap_flag) else $error("capture flag not raised");

    property p_pc_read;
        i_ce && i_rd && i_addr == `SBT_OFS_PC |=> o_rdata == {`SBT_ZERO16, $past(s_reg.pc)};
    endproperty
    a_pc_read: assert property (p_pc_read) else $error("prescale read wrong");

    property p_freeze;
        !i_ce |=> s_reg == $past(s_reg);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved with clock enable low");

    // A flag read shows the pending flags in the low bits and zero above.
    property p_ir_read;
        i_ce && i_rd && i_addr == `SBT_OFS_IR
            |=> o_rdata[`SBT_NIRQ-1:0] == $past(s_reg.ir) && o_rdata[`SBT_DW-1:`SBT_NIRQ] == '0;
    endproperty
    a_ir_read: assert property (p_ir_read) else $error("flag read wrong");

    // Every raised source shows in the flag register on the next cycle.
    property p_flag_set;
        i_ce |=> (s_reg.ir & $past(set_flags)) == $past(set_flags);
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("raised flag missing");

    // A write to the capture register is ignored.
    property p_cap_ro;
        i_ce && i_wr && i_addr == `SBT_OFS_CAP && !cap_evt |=> $stable(s_reg.cap);
    endproperty
    a_cap_ro: assert property (p_cap_ro) else $error("capture register took a write");

    // In counter mode nothing moves without a selected edge.
    property p_count_mode;
        i_ce && s_reg.mode != SBT_MODE_TIMER && !cnt_evt && !s_reg.rst && !wr_tc && !wr_pc
            |=> $stable(s_reg.tc) && $stable(s_reg.pc);
    endproperty
    a_count_mode: assert property (p_count_mode) else $error("count moved without a selected edge");

    // Read data stands for one cycle only.
    property p_rd_idle;
        i_ce && !i_rd |=> o_rdata == '0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data stood too long");

    // Reset clears all state and the match pins, whatever the clock enable does.
    property p_reset_zero;
        disable iff (1'b0) !i_rstn |=> s_reg == '0 && o_match == '0;
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("state not cleared by reset");

    // Main scenarios that the bench is expected to reach.
    c_wrap: cover property (i_ce && tick && s_reg.pc == s_reg.pr && s_reg.pr != `SBT_ZERO16);
    c_match_reset: cover property (i_ce && tick && rst_hit);
    c_capture: cover property (i_ce && cap_evt && s_reg.tc != `SBT_ZERO16);
    c_pwm: cover property (s_reg.pwm[0] && $rose(pins[0]));
    c_stop: cover property (i_ce && stop_now);
endmodule : sbt_timer

//--- dv/sbt_pin_model.sv
// Far-side model of the capture input pin and the match output pins.
`timescale 1ns/10ps
module sbt_pin_model
(
    input wire logic i_core_clk,
    input wire logic i_go,
    input wire logic [2:0] i_match,
    output logic o_cap,
    output logic [2:0] o_seen
);
    logic [2:0] cnt_reg = 3'h0;
    logic [2:0] seen_reg;
    // One request gives a pulse two cycles high, then the line rests low.
    // The match pins are latched one cycle later, as the far side sees them.
    always_ff @(posedge i_core_clk)
    begin
        seen_reg <= i_match;
        if (i_go)
            cnt_reg <= 3'h2;
        else if (cnt_reg != 3'h0)
            cnt_reg <= cnt_reg - 3'h1;
    end
    assign o_cap = (cnt_reg != 3'h0);
    assign o_seen = seen_reg;
endmodule : sbt_pin_model

//--- dv/sbt_timer_tb_top.sv
// Self-checking testbench of the sixteen-bit counter/timer.
`timescale 1ns/10ps
`include "sbt_cfg.svh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_errors++; \
    $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
module sbt_timer_tb_top
    import sbt_pkg::*;
;
    logic i_core_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic [`SBT_AW-1:0] i_addr = 8'h00;
    logic [`SBT_DW-1:0] i_wdata = 32'h0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic go = 1'b0;
    logic ce = 1'b1;
    logic cap;
    logic [2:0] seen;
    logic [`SBT_DW-1:0] o_rdata;
    logic [2:0] o_match;
    logic [`SBT_DW-1:0] d;
    int n_errors = 0;
    int checks = 0;
    logic [7:0] ofs [16] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C,
                             8'h20, 8'h24, 8'h28, 8'h2C, 8'h3C, 8'h70, 8'h74, 8'h40};
    // Clock of 200 MHz.
    always #2.5 i_core_clk = ~i_core_clk;
    sbt_timer #(.NUM_PINS(3)) sbt_timer_i (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_ce(ce),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_cap(cap), .o_match(o_match));
    sbt_pin_model sbt_pin_model_i (.i_core_clk(i_core_clk), .i_go(go), .i_match(o_match), .o_cap(cap),
        .o_seen(seen));
    // Register write: strobe one cycle, then one quiet edge so no strobe is assigned twice at once.
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= v;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
        @(posedge i_core_clk);
    endtask : wr
    // Register read: data stands in the cycle after the strobe and is taken at that cycle's closing edge.
    task automatic rd(input logic [7:0] a);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        @(posedge i_core_clk);
        d = o_rdata;
    endtask : rd
    // Asks the pin model for one high pulse and lets it settle.
    task automatic pulse();
        go <= 1'b1;
        @(posedge i_core_clk);
        go <= 1'b0;
        repeat (6) @(posedge i_core_clk);
    endtask : pulse
    task automatic idle(input int n);
        repeat (n) @(posedge i_core_clk);
    endtask : idle
    task automatic summarize();
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : summarize
    // Watchdog well beyond the few hundred cycles the tests take.
    initial
    begin
        idle(20000);
        n_errors++;
        summarize();
    end
    // Main sequence.
    initial
    begin
        idle(5);
        i_rstn <= 1'b1;
        @(posedge i_core_clk);
        for (int i = 0; i < 16; i++)
        begin
            rd(ofs[i]);
            `CHK(d, 32'h0)
        end
        wr(`SBT_OFS_CAP, 32'hFFFF);
        rd(`SBT_OFS_CAP);
        `CHK(d, 32'h0)
        $display("test reset done");
        wr(`SBT_OFS_PR, 32'h2);
        wr(`SBT_OFS_TCR, 32'h1);
        idle(7);
        wr(`SBT_OFS_TCR, 32'h0);
        rd(`SBT_OFS_TC);
        `CHK(d, 32'h3)
        rd(`SBT_OFS_PC);
        `CHK(d, 32'h0)
        wr(`SBT_OFS_PC, 32'h1);
        rd(`SBT_OFS_PC);
        `CHK(d, 32'h1)
        wr(`SBT_OFS_TCR, 32'h2);
        rd(`SBT_OFS_TC);
        `CHK(d, 32'h0)
        wr(`SBT_OFS_TCR, 32'h0);
        wr(`SBT_OFS_PR, 32'h0);
        $display("test prescale done");
        wr(`SBT_OFS_MR0, 32'h4);
        wr(`SBT_OFS_MCR, 32'h3);
        wr(`SBT_OFS_TCR, 32'h1);
        idle(20);
        wr(`SBT_OFS_TCR, 32'h0);
        rd(`SBT_OFS_TC);
        `CHK(d[15:0] <= 16'h0004, 1'b1)
        rd(`SBT_OFS_IR);
        `CHK(d, 32'h1)
        wr(`SBT_OFS_IR, 32'h0);
        rd(`SBT_OFS_IR);
        `CHK(d, 32'h1)
        wr(`SBT_OFS_IR, 32'h1);
        rd(`SBT_OFS_IR);
        `CHK(d, 32'h0)
        // Channel 1 stops with a flag, channel 2 only flags.
        wr(`SBT_OFS_TC, 32'h0);
        wr(`SBT_OFS_MR1, 32'h3);
        wr(`SBT_OFS_MR2, 32'h1);
        wr(`SBT_OFS_MCR, 32'h68);
        wr(`SBT_OFS_TCR, 32'h1);
        idle(10);
        rd(`SBT_OFS_TCR);
        `CHK(d, 32'h0)
        rd(`SBT_OFS_TC);
        `CHK(d, 32'h3)
        rd(`SBT_OFS_IR);
        `CHK(d, 32'h6)
        wr(`SBT_OFS_MCR, 32'h0);
        wr(`SBT_OFS_IR, 32'h1F);
        $display("test match done");
        wr(`SBT_OFS_TC, 32'h1234);
        wr(`SBT_OFS_CCR, 32'h5);
        pulse();
        rd(`SBT_OFS_CAP);
        `CHK(d, 32'h1234)
        rd(`SBT_OFS_IR);
        `CHK(d, 32'h10)
        // Counter mode on rising, falling and both edges.
        for (int m = 1; m < 4; m++)
        begin
            wr(`SBT_OFS_TC, 32'h0);
            wr(`SBT_OFS_COUNT_SOURCE_CONTROL, m);
            wr(`SBT_OFS_TCR, 32'h1);
            pulse();
            pulse();
            wr(`SBT_OFS_TCR, 32'h0);
            rd(`SBT_OFS_TC);
            `CHK(d, (m == 3) ? 32'h4 : 32'h2)
        end
        // Any input select but the capture pin leaves the count still.
        wr(`SBT_OFS_TC, 32'h0);
        wr(`SBT_OFS_COUNT_SOURCE_CONTROL, 32'h5);
        wr(`SBT_OFS_TCR, 32'h1);
        pulse();
        wr(`SBT_OFS_TCR, 32'h0);
        rd(`SBT_OFS_TC);
        `CHK(d, 32'h0)
        wr(`SBT_OFS_COUNT_SOURCE_CONTROL, 32'h0);
        $display("test capture done");
        wr(`SBT_OFS_TC, 32'h0);
        wr(`SBT_OFS_MR0, 32'h2);
        wr(`SBT_OFS_MR1, 32'h2);
        wr(`SBT_OFS_MR2, 32'h2);
        wr(`SBT_OFS_EMR, 32'h1E4);
        idle(2);
        `CHK(o_match, 3'b100)
        wr(`SBT_OFS_TCR, 32'h1);
        idle(6);
        wr(`SBT_OFS_TCR, 32'h0);
        idle(2);
        `CHK(o_match, 3'b011)
        `CHK(seen, 3'b011)
        // A low clock enable freezes counting for ten cycles.
        wr(`SBT_OFS_TC, 32'h0);
        wr(`SBT_OFS_TCR, 32'h1);
        ce <= 1'b0;
        idle(10);
        ce <= 1'b1;
        wr(`SBT_OFS_TCR, 32'h0);
        rd(`SBT_OFS_TC);
        `CHK(d, 32'h2)
        // Single-edge PWM on pin 0; software keeps channel 3 for the period.
        wr(`SBT_OFS_EMR, 32'h0);
        wr(`SBT_OFS_MR0, 32'h3);
        wr(`SBT_OFS_MR3, 32'h7);
        wr(`SBT_OFS_MCR, 32'h400);
        wr(`SBT_OFS_PWMC, 32'h9);
        wr(`SBT_OFS_TC, 32'h0);
        idle(2);
        `CHK(o_match[0], 1'b0)
        wr(`SBT_OFS_TC, 32'h5);
        idle(2);
        `CHK(o_match[0], 1'b1)
        $display("test pins done");
        summarize();
    end
endmodule : sbt_timer_tb_top
